// ---- logic/dram_refresh_regs.svh ----
// timing counts and limits of the dram refresh stall controller
`ifndef DRAM_REFRESH_REGS_SVH
`define DRAM_REFRESH_REGS_SVH
// reference clock rate in MHz (10 ns period)
`define REF_CLK_MHZ 100
// whole-array refresh period in milliseconds
`define REFRESH_PERIOD_MS 2
// reference clock cycles in one refresh period, rounded down
`define REFRESH_PERIOD_CYCLES (`REFRESH_PERIOD_MS * 1000 * `REF_CLK_MHZ)
// reads needed to refresh the whole array
`define REFRESH_ROWS 32
// spacing of distributed refresh reads in microseconds
`define REFRESH_SPACING_US 64
// processor cycle count at which a refresh request fires
`define REQ_TERMINAL_COUNT 6'h3F
// recommended stall length in processor cycles
`define STALL_CYCLES_DEFAULT 2
// stall length of the fetch-marker scheme
`define FETCH_STALL_CYCLES 1
`endif

// ---- logic/dram_refresh_pkg.sv ----
// types shared by the dram refresh stall controller
`default_nettype none
package dram_refresh_pkg;
  // how the controller learns that the processor has stopped
  typedef enum logic [1:0] {
    MODE_BUS_AVAIL = 2'h0,
    MODE_READ_SEEN = 2'h1,
    MODE_FETCH = 2'h2
  } stop_mode_t;
  // refresh sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ARM,
    ST_NEXT,
    ST_REFRESH
  } refresh_state_t;
  // processor pins watched by the controller
  typedef struct packed {
    logic phi2;
    logic rw;
    logic fetch;
    logic bus_avail;
  } cpu_pins_t;
endpackage : dram_refresh_pkg
`default_nettype wire

// ---- logic/dram_refresh_stall_controller.sv ----
// dram refresh controller that stalls the processor through its ready input
`timescale 1ns/1ns
`default_nettype none
`include "dram_refresh_regs.svh"
// How it works
// - whole array refreshed within two milliseconds; late sweep raises a flag
// - thirty-two reads per sweep, one roughly every sixty-four microseconds
// - processor cycle counter pulses a refresh request each pass through 63
// - ready driven low to stall processor before touching memory, except in the fetch scheme, which drops it as the lines are taken
// - each refresh is a read done while the processor is stopped
// - without bus-available, ready low then wait for a read cycle
// - read/write and bus-available trusted only from phase two onward
// - refresh confined to the N minus half cycles left of stall
// - address lines handed back at the start of phase one
// - default stall is two cycles, giving one and a half for refresh
// - fetch scheme takes address lines at start of cycle after fetch
// - fetch scheme drives ready low in phase one after the fetch
// - next phase one returns address lines and raises ready together
module dram_refresh_stall_controller #(
  parameter int STALL_CYCLES = `STALL_CYCLES_DEFAULT,
  parameter int PERIOD_CYCLES = `REFRESH_PERIOD_CYCLES,
  parameter int ROW_W = 5
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cpu_phi2,
  input wire logic cpu_rw,
  input wire logic cpu_fetch,
  input wire logic cpu_bus_avail,
  input wire logic [1:0] stop_mode,
  output logic cpu_rdy,
  output logic addr_own,
  output logic [ROW_W-1:0] row_addr,
  output logic refresh_req,
  output logic refresh_late
);

  // stop_mode (two bits), phi2, rw, fetch and bus_avail all come from pins
  localparam int PIN_W = 6;
  // watchdog wide enough to reach the full refresh period
  localparam int CNT_W = $clog2(PERIOD_CYCLES + 1);
  // stall countdown; limits STALL_CYCLES to 15 processor cycles
  localparam int LEFT_W = 4;

  // pin synchronisers: three stages, a change counts once stages two and three agree
  // four reference clocks of latency, small against a processor phase
  // the filter holds its value while stages two and three disagree
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] filt_q;

  assign pin_raw = {stop_mode, cpu_phi2, cpu_rw, cpu_fetch, cpu_bus_avail};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      // first stage feeds only the second; filter looks at stages two and three
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // filtered pins split into fields
  dram_refresh_pkg::cpu_pins_t pins;
  dram_refresh_pkg::stop_mode_t mode;
  assign pins = dram_refresh_pkg::cpu_pins_t'(filt_q[3:0]);
  assign mode = dram_refresh_pkg::stop_mode_t'(filt_q[5:4]);

  // phase edges of the processor clock
  // phi1 start is the fall of phase two; counting and hand-back key off it
  logic phi2_prev_q;
  wire logic phi2_rise;
  wire logic phi1_start;
  assign phi2_rise = pins.phi2 & ~phi2_prev_q;
  assign phi1_start = ~pins.phi2 & phi2_prev_q;

  // previous filtered phase for edge detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phi2_prev_q <= 1'b0;
    end else begin
      phi2_prev_q <= pins.phi2;
    end
  end

  // processor cycle counter: 64 cycles at 1 MHz spaces the reads about 64 us apart
  // the processor clock runs free, so the spacing holds through stalls
  logic [5:0] cyc_q;
  logic [5:0] cyc_d;
  logic req_q;
  wire logic cyc_wrap;
  wire logic cyc_last;
  // the six-bit count rolls from 63 back to 0 on its own
  assign cyc_last = (cyc_q == `REQ_TERMINAL_COUNT);
  assign cyc_wrap = phi1_start && cyc_last;
  assign cyc_d = phi1_start ? cyc_q + 6'h01 : cyc_q;

  // counter and request pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q <= 6'h00;
      req_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      req_q <= cyc_wrap; // one-cycle request pulse
    end
  end

  // sequencer state and its working registers
  dram_refresh_pkg::refresh_state_t state_q;
  dram_refresh_pkg::refresh_state_t state_d;
  logic pend_q;
  logic pend_d;
  logic rdy_q;
  logic rdy_d;
  logic own_q;
  logic own_d;
  logic [LEFT_W-1:0] left_q;
  logic [LEFT_W-1:0] left_d;
  logic [ROW_W-1:0] row_q;
  logic [ROW_W-1:0] row_d;

  // reload values and row arithmetic
  wire logic [LEFT_W-1:0] left_stall;
  wire logic [LEFT_W-1:0] left_fetch;
  wire logic [ROW_W-1:0] row_next;
  wire logic in_refresh;
  wire logic row_last;
  assign left_stall = LEFT_W'(STALL_CYCLES);
  assign left_fetch = LEFT_W'(`FETCH_STALL_CYCLES);
  assign row_next = row_q + ROW_W'(1); // wraps after the last row
  assign in_refresh = (state_q == dram_refresh_pkg::ST_REFRESH);
  assign row_last = (row_q == {ROW_W{1'b1}});

  // stop detection, valid only while phase two is high
  wire logic stop_seen;
  wire logic fetch_seen;
  wire logic use_ba;
  wire logic done_step;
  wire logic accept;
  wire logic fresh_phase;
  logic fresh_q;
  assign use_ba = (mode == dram_refresh_pkg::MODE_BUS_AVAIL);
  // a phase two already running when ready fell proves nothing
  assign fresh_phase = phi2_rise | fresh_q;
  assign stop_seen = pins.phi2 && fresh_phase && !rdy_q &&
                     (use_ba ? pins.bus_avail : pins.rw);
  // the cycle after a fetch can never be a write, so stopping there is safe
  assign fetch_seen = pins.phi2 && pins.fetch;
  assign done_step = phi1_start && (left_q == 4'h1);
  assign accept = (state_d == dram_refresh_pkg::ST_REFRESH) && !in_refresh;

  // only phase-two starts seen while holding count as fresh
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fresh_q <= 1'b0;
    end else if (state_q != dram_refresh_pkg::ST_HOLD) begin
      fresh_q <= 1'b0;
    end else if (phi2_rise) begin
      fresh_q <= 1'b1;
    end
  end

  // a request landing in the same cycle the pending one is taken is kept
  // the pending flag is only one deep: extra requests merge
  assign pend_d = req_q | (pend_q & ~accept);

  // next-state logic
  always_comb begin
    state_d = state_q;
    rdy_d = rdy_q;
    own_d = own_q;
    left_d = left_q;
    row_d = row_q;
    unique case (state_q)
      dram_refresh_pkg::ST_IDLE: begin
        if (pend_q) begin
          if (mode == dram_refresh_pkg::MODE_FETCH) begin
            // fetch scheme stalls only once a fetch has been seen
            state_d = dram_refresh_pkg::ST_ARM;
          end else begin
            // stall first so both sides never drive memory together
            rdy_d = 1'b0;
            state_d = dram_refresh_pkg::ST_HOLD;
          end
        end
      end
      dram_refresh_pkg::ST_HOLD: begin
        // bus_avail or a read in a fresh phase two shows the stop
        if (stop_seen) begin
          // first half cycle is lost; take the bus in phase two
          own_d = 1'b1;
          left_d = left_stall;
          state_d = dram_refresh_pkg::ST_REFRESH;
        end
      end
      dram_refresh_pkg::ST_ARM: begin
        // wait for the phase two of a fetch cycle
        if (fetch_seen) begin
          state_d = dram_refresh_pkg::ST_NEXT;
        end
      end
      dram_refresh_pkg::ST_NEXT: begin
        if (phi1_start) begin
          // whole cycle after the fetch belongs to refresh
          rdy_d = 1'b0;
          own_d = 1'b1;
          left_d = left_fetch;
          state_d = dram_refresh_pkg::ST_REFRESH;
        end
      end
      dram_refresh_pkg::ST_REFRESH: begin
        // count phase-one starts; the last one ends the stall
        if (phi1_start) begin
          left_d = left_q - 4'h1;
        end
        if (done_step) begin
          // hand back at phase one so memory gets a full cycle for the processor
          own_d = 1'b0;
          rdy_d = 1'b1;
          row_d = row_next;
          state_d = dram_refresh_pkg::ST_IDLE;
        end
      end
      default: begin
        // unused state codes fall back to idle
        state_d = dram_refresh_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  // every register loads on each clock; next values hold by default
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= dram_refresh_pkg::ST_IDLE;
      pend_q <= 1'b0;
      rdy_q <= 1'b1;
      own_q <= 1'b0;
      left_q <= 4'h0;
      row_q <= '0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      rdy_q <= rdy_d;
      own_q <= own_d;
      left_q <= left_d;
      row_q <= row_d;
    end
  end

  // sweep watchdog: the 32 reads must finish within one refresh period
  logic [CNT_W-1:0] sweep_q;
  logic late_q;
  wire logic sweep_done;
  wire logic sweep_over;
  assign sweep_done = done_step && in_refresh && row_last;
  assign sweep_over = (sweep_q == CNT_W'(PERIOD_CYCLES));

  // saturates so the flag cannot re-arm by counter roll-over
  // the flag only warns; refreshes keep their normal pace
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sweep_q <= '0;
      late_q <= 1'b0;
    end else begin
      if (sweep_done) begin
        sweep_q <= '0;
      end else if (!sweep_over) begin
        sweep_q <= sweep_q + CNT_W'(1);
      end
      if (sweep_over && !sweep_done) begin
        late_q <= 1'b1; // sticky until reset
      end
    end
  end

  // outputs straight from flip-flops
  // row_addr only carries meaning while addr_own is high
  assign cpu_rdy = rdy_q;
  assign addr_own = own_q;
  assign row_addr = row_q; // row presented while addr_own is high
  assign refresh_req = req_q;
  assign refresh_late = late_q;

endmodule : dram_refresh_stall_controller
`default_nettype wire

// ---- bench/dram_refresh_chk.sv ----
// port assertions for the dram refresh stall controller
`timescale 1ns/1ns
`default_nettype none
module dram_refresh_chk #(
  parameter int ROW_W = 5
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cpu_phi2,
  input wire logic cpu_rw,
  input wire logic cpu_fetch,
  input wire logic cpu_bus_avail,
  input wire logic [1:0] stop_mode,
  input wire logic cpu_rdy,
  input wire logic addr_own,
  input wire logic [ROW_W-1:0] row_addr,
  input wire logic refresh_req,
  input wire logic refresh_late
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // raw pins looked at 3 edges back, well inside a processor phase
  a_req_one_pulse: assert property (refresh_req |=> !refresh_req)
    else $error("request too long");
  a_own_while_stall: assert property (addr_own |-> !cpu_rdy)
    else $error("lines taken, rdy high");
  a_rdy_before_own: assert property ($fell(cpu_rdy) && stop_mode != 2'h2 |-> !addr_own)
    else $error("lines taken with stall");
  a_stop_seen: assert property ($rose(addr_own) && stop_mode != 2'h2 |-> $past(cpu_phi2, 3)
    && (stop_mode == 2'h0 ? $past(cpu_bus_avail, 3) : $past(cpu_rw, 3)))
    else $error("taken before stop seen");
  a_fetch_take: assert property ($rose(addr_own) && stop_mode == 2'h2 |-> $fell(cpu_rdy))
    else $error("fetch take not with rdy");
  a_release_phi1: assert property ($fell(addr_own) |-> !$past(cpu_phi2, 3))
    else $error("release outside phase one");
  a_release_together: assert property ($fell(addr_own) |-> $rose(cpu_rdy))
    else $error("rdy not with release");
  a_row_advance: assert property ($fell(addr_own) |-> row_addr == $past(row_addr) + 1'b1)
    else $error("row not advanced");
  c_req: cover property (refresh_req);
  c_take_avail: cover property ($rose(addr_own) && stop_mode == 2'h0);
  c_take_fetch: cover property ($rose(addr_own) && stop_mode == 2'h2);
endmodule : dram_refresh_chk
bind dram_refresh_stall_controller dram_refresh_chk #(.ROW_W(ROW_W)) chk (.ref_clk(ref_clk),
  .rstn(rstn), .cpu_phi2(cpu_phi2), .cpu_rw(cpu_rw), .cpu_fetch(cpu_fetch),
  .cpu_bus_avail(cpu_bus_avail), .stop_mode(stop_mode), .cpu_rdy(cpu_rdy),
  .addr_own(addr_own), .row_addr(row_addr), .refresh_req(refresh_req),
  .refresh_late(refresh_late));
`default_nettype wire

// ---- bench/cpu_model.sv ----
// processor model: free two-phase clock, bus cycles, ready stall
`timescale 1ns/1ns
`default_nettype none
module cpu_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rdy,
  output var dram_refresh_pkg::cpu_pins_t pins
);
  int ph_q;
  logic [1:0] cyc_q;
  logic stop_q;
  // fetch, read, write, read: a write never follows a fetch
  wire logic rd_w = (cyc_q != 2'h2);
  // stop decided at phase two rise, cycle repeats while stopped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 0;
      cyc_q <= 2'h0;
      stop_q <= 1'b0;
      pins <= '0;
    end else begin
      ph_q <= (ph_q == HALF - 1) ? 0 : ph_q + 1;
      if (ph_q == HALF - 1) begin
        pins.phi2 <= !pins.phi2;
        pins.bus_avail <= !pins.phi2 && !rdy && rd_w;
        if (!pins.phi2) begin
          stop_q <= !rdy && rd_w;
        end else if (!stop_q) begin
          cyc_q <= cyc_q + 2'h1;
        end
      end
      pins.rw <= rd_w;
      pins.fetch <= (cyc_q == 2'h0);
    end
  end
endmodule : cpu_model
`default_nettype wire

// ---- bench/tb_dram_refresh_stall_controller.sv ----
// self-checking bench for the dram refresh stall controller
`timescale 1ns/1ns
`default_nettype none
module tb_dram_refresh_stall_controller;
  localparam int PCYC = 20; // ref clocks per processor cycle
  logic ref_clk = 1'b0;
  logic rstn = 1'b1;
  logic [1:0] stop_mode = 2'h2;
  dram_refresh_pkg::cpu_pins_t pins;
  logic cpu_rdy, addr_own, refresh_req, refresh_late;
  logic [4:0] row_addr;
  logic [4:0] row;
  int miscompares = 0;
  int checks = 0;
  int n;
  cpu_model #(.HALF(PCYC / 2)) cpu (.ref_clk(ref_clk), .rstn(rstn), .rdy(cpu_rdy), .pins(pins));
  // short period keeps the late watchdog inside the run
  dram_refresh_stall_controller #(.PERIOD_CYCLES(50000)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .cpu_phi2(pins.phi2), .cpu_rw(pins.rw), .cpu_fetch(pins.fetch),
    .cpu_bus_avail(pins.bus_avail), .stop_mode(stop_mode), .cpu_rdy(cpu_rdy),
    .addr_own(addr_own), .row_addr(row_addr), .refresh_req(refresh_req),
    .refresh_late(refresh_late));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic tick();
    @(posedge ref_clk);
    #1;
    n++;
  endtask : tick
  task automatic do_reset(input logic [1:0] mode);
    @(posedge ref_clk);
    rstn <= 1'b0;
    stop_mode <= mode;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    tick();
    check(cpu_rdy && !addr_own && row_addr === 5'h00 && !refresh_req && !refresh_late, "reset");
  endtask : do_reset
  task automatic wait_req();
    n = 0;
    do tick(); while (refresh_req !== 1'b1 && n < 3000);
    check(refresh_req === 1'b1, "no refresh request");
  endtask : wait_req
  // one refresh: n ends as the count of cycles the lines were held
  task automatic wait_stall();
    n = 0;
    while (addr_own !== 1'b1 && n < 3000) tick();
    check(addr_own === 1'b1, "no refresh taken");
    row = row_addr;
    check(cpu_rdy === 1'b0, "lines taken, rdy high");
    n = 0;
    while (addr_own === 1'b1 && n < 200) tick();
    check(addr_own === 1'b0, "lines not returned");
    check(cpu_rdy === 1'b1, "rdy not raised");
    check(row_addr === row + 5'h01, "row not advanced");
  endtask : wait_stall
  task automatic t_req_period();
    wait_req();
    wait_req();
    check(n == 64 * PCYC, "request spacing");
  endtask : t_req_period
  // fetch scheme: one full cycle per row, 33 rows to see the wrap
  task automatic t_fetch_sweep();
    do_reset(2'h2);
    for (int i = 0; i < 33; i++) begin
      wait_stall();
      check(row === 5'(i), "row order");
      check(n >= PCYC - 1 && n <= PCYC + 1, "fetch stall length");
    end
    check(refresh_late === 1'b0, "late within period");
  endtask : t_fetch_sweep
  // bus-available and read-seen schemes: one and a half cycles held
  task automatic t_stop_modes();
    for (int m = 0; m < 4; m++) begin
      if (m == 2) continue;
      do_reset(2'(m));
      wait_stall();
      check(n >= 3 * PCYC / 2 - 1 && n <= 3 * PCYC / 2 + 2, "stall length");
      check(row === 5'h00, "first row");
    end
  endtask : t_stop_modes
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    rstn <= 1'b0;
    do_reset(2'h2);
    t_req_period();
    t_fetch_sweep();
    t_stop_modes();
    complete_run();
  end
  // hang guard, well past the expected run of about 50000 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    $display("CHECK FAILED %0t timeout", $time);
    complete_run();
  end
endmodule : tb_dram_refresh_stall_controller
`default_nettype wire
